/* shared/pcie_link_power_mgmt_pkg.sv */
package pcie_link_power_mgmt_pkg;

    // ========================================================================
    // Register offsets (byte addresses in configuration space)
    // ========================================================================
    localparam logic [11:0] OFS_PM_CTRL_STATUS  = 12'h044;
    localparam logic [11:0] OFS_LINK_CONTROL    = 12'h078;
    localparam logic [11:0] OFS_PB_CAP_HEADER   = 12'h138;
    localparam logic [11:0] OFS_PB_INDEX        = 12'h13c;
    localparam logic [11:0] OFS_PB_DATA         = 12'h140;
    localparam logic [11:0] OFS_PB_CAPABILITY   = 12'h144;
    localparam logic [11:0] OFS_LINK_PM_USER    = 12'h1e0;

    // ========================================================================
    // Extended capability header fields
    // ========================================================================
    localparam logic [15:0] PB_CAP_ID           = 16'h0004;
    localparam logic [3:0]  PB_CAP_VERSION      = 4'h1;
    localparam logic [11:0] PB_NEXT_OFFSET      = 12'h148;
    localparam logic [31:0] PB_CAP_HEADER       = {PB_NEXT_OFFSET, PB_CAP_VERSION, PB_CAP_ID};
    localparam logic [31:0] PB_CAPABILITY_VAL   = 32'h0000_0001;

    // ========================================================================
    // Power budget entries
    // ========================================================================
    localparam logic [7:0]  PB_ENTRY_LAST       = 8'h01;
    localparam logic [1:0]  SCALE_1_0           = 2'h0;
    localparam logic [1:0]  SCALE_0_1           = 2'h1;
    localparam logic [1:0]  SCALE_0_01          = 2'h2;
    localparam logic [1:0]  SCALE_0_001         = 2'h3;
    localparam logic [2:0]  PM_SUBSTATE_0       = 3'h0;
    localparam logic [2:0]  TYPE_PME_AUX        = 3'h0;
    localparam logic [2:0]  TYPE_AUX            = 3'h1;
    localparam logic [2:0]  TYPE_IDLE           = 3'h2;
    localparam logic [2:0]  TYPE_SUSTAINED      = 3'h3;
    localparam logic [2:0]  TYPE_MAXIMUM        = 3'h7;
    localparam logic [2:0]  RAIL_12V            = 3'h0;
    localparam logic [2:0]  RAIL_3V3            = 3'h1;
    localparam logic [2:0]  RAIL_1V8            = 3'h2;
    localparam logic [2:0]  RAIL_THERMAL        = 3'h7;
    localparam logic [7:0]  PB0_BASE_POWER      = 8'h10;
    localparam logic [7:0]  PB1_BASE_POWER      = 8'h05;

    // ========================================================================
    // Device power states and ASPM control codes
    // ========================================================================
    localparam logic [1:0]  DSTATE_D0           = 2'h0;
    localparam logic [1:0]  DSTATE_D1           = 2'h1;
    localparam logic [1:0]  DSTATE_D2           = 2'h2;
    localparam logic [1:0]  DSTATE_D3HOT        = 2'h3;
    localparam int          ASPM_L0S_BIT        = 0;
    localparam int          ASPM_L1_BIT         = 1;

    // ========================================================================
    // User configuration bit positions
    // ========================================================================
    localparam int          UCFG_IDLE_SEL_BIT   = 0;
    localparam int          UCFG_L1_DIS_BIT     = 7;
    localparam int          UCFG_L0S_DIS_BIT    = 10;
    localparam int          UCFG_PME_RES_BIT    = 12;
    localparam logic [31:0] UCFG_WRITE_MASK     = 32'h0000_1481;

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int          CLK_MHZ             = 125;
    localparam int          L0S_IDLE_SHORT_NS   = 1000;
    localparam int          L0S_IDLE_LONG_NS    = 4000;
    localparam logic [9:0]  L0S_IDLE_SHORT_CYC  = 10'((L0S_IDLE_SHORT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0]  L0S_IDLE_LONG_CYC   = 10'((L0S_IDLE_LONG_NS * CLK_MHZ + 999) / 1000);

    // ========================================================================
    // Upstream link state
    // ========================================================================
    typedef enum logic [5:0] {
        LINK_L0     = 6'b000001,
        LINK_L0S    = 6'b000010,
        LINK_L1NEG  = 6'b000100,
        LINK_L1     = 6'b001000,
        LINK_L23NEG = 6'b010000,
        LINK_L23    = 6'b100000
    } link_state_t;

endpackage

/* logic/pcie_link_power_mgmt.sv */
`timescale 1ns/100ps
// Summary of operation
// [R01] Header returns ID 0004h, version 1, next 148h
// [R02] Index selects power budget dword 0 or 1
// [R03] Dword carries base power and scale code
// [R04] Dword carries substate 000b and D-state
// [R05] Dword carries operating condition type code
// [R06] Dword carries power rail code
// [R07] Capability bit 0 reads one
// [R08] L0s needs 1 us or 4 us idle
// [R09] L1 disable bit blocks L1 in D3hot
// [R10] L0s disable bit blocks L0s entry
// [R11] Forward PME on USB resume in D1-D3hot
// [R12] Low D-states: config only, request L1
// [R13] D3hot to D0 keeps configuration
// [R14] L0s puts transmit idle, receiver always may
// [R15] Pending packet ends transmit L0s
// [R16] ASPM L1: upstream negotiates, either side exits
// [R17] Non-zero D-state: negotiate L1, either exits
// [R18] Turn-off: send ack, negotiate L2/L3 Ready
// [R19] L2/L3 Ready disconnects USB unless suspended; code does so only with rcMode low
// [R20] Root-complex mode issues turn-off downstream
// [R21] Downstream L1 only on endpoint request
// [R22] L2/L3 Ready freezes FC timers, clocks stoppable
// [R23] D-state codes D0 00b to D3hot 11b
// [R24] ASPM codes: off, L0s, L1, both
// [R25] Unsupported index reads zero data
module pcie_link_power_mgmt
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Configuration access
    input  wire logic        cfgReq,
    input  wire logic        cfgWrite,
    input  wire logic [11:0] cfgAddr,
    input  wire logic [3:0]  cfgByteEn,
    input  wire logic [31:0] cfgWdata,
    output logic             cfgAck,
    output logic [31:0]      cfgRdata,
    // Upstream link events
    input  wire logic        txPending,
    input  wire logic        rxIdle,
    input  wire logic        partnerExit,
    input  wire logic        l1Granted,
    input  wire logic        l1Rejected,
    input  wire logic        turnOffRcvd,
    input  wire logic        l23Granted,
    output logic             txElecIdle,
    output logic             rxLowPower,
    output logic             l1Request,
    output logic             pmeToAckSend,
    output logic             l23Request,
    output logic [5:0]       linkState,
    output logic             configOnly,
    // Mode and USB side
    input  wire logic        rcMode,
    input  wire logic        usbSuspended,
    input  wire logic        usbResumeDetect,
    output logic             pmeSend,
    output logic             usbDisconnect,
    output logic             fcTimerFreeze,
    output logic             clockStopAllow,
    // Downstream port (root-complex mode)
    input  wire logic        turnOffCmd,
    input  wire logic        dsTurnOffAcked,
    input  wire logic        epL1Request,
    input  wire logic        dsL1Granted,
    input  wire logic        dsExit,
    output logic             turnOffMsgSend,
    output logic             dsL1,
    output logic             dsL23Ready
);

    // ========================================================================
    // Configuration registers
    // ========================================================================
    logic [1:0]  powerState_q;
    logic [1:0]  aspmCtrl_q;
    logic [7:0]  pbIndex_q;
    logic [31:0] userCfg_q;
    logic        cfgAck_q;
    logic [31:0] cfgRdata_q;

    // Address decode and byte-lane write strobes
    wire hitPmCsr  = (cfgAddr == pcie_link_power_mgmt_pkg::OFS_PM_CTRL_STATUS);
    wire hitLnkCtl = (cfgAddr == pcie_link_power_mgmt_pkg::OFS_LINK_CONTROL);
    wire hitHdr    = (cfgAddr == pcie_link_power_mgmt_pkg::OFS_PB_CAP_HEADER);
    wire hitIndex  = (cfgAddr == pcie_link_power_mgmt_pkg::OFS_PB_INDEX);
    wire hitData   = (cfgAddr == pcie_link_power_mgmt_pkg::OFS_PB_DATA);
    wire hitCap    = (cfgAddr == pcie_link_power_mgmt_pkg::OFS_PB_CAPABILITY);
    wire hitUser   = (cfgAddr == pcie_link_power_mgmt_pkg::OFS_LINK_PM_USER);
    wire wrLane0   = cfgReq & cfgWrite & cfgByteEn[0];
    wire wrLane1   = cfgReq & cfgWrite & cfgByteEn[1];

    // Power budget entries; index past the last one reads as zero
    wire [31:0] pbEntry0 = {11'h000, pcie_link_power_mgmt_pkg::RAIL_3V3,
                            pcie_link_power_mgmt_pkg::TYPE_MAXIMUM,
                            pcie_link_power_mgmt_pkg::DSTATE_D0,
                            pcie_link_power_mgmt_pkg::PM_SUBSTATE_0,
                            pcie_link_power_mgmt_pkg::SCALE_0_1,
                            pcie_link_power_mgmt_pkg::PB0_BASE_POWER}; // R03 R04 R05 R06
    wire [31:0] pbEntry1 = {11'h000, pcie_link_power_mgmt_pkg::RAIL_3V3,
                            pcie_link_power_mgmt_pkg::TYPE_PME_AUX,
                            pcie_link_power_mgmt_pkg::DSTATE_D3HOT,
                            pcie_link_power_mgmt_pkg::PM_SUBSTATE_0,
                            pcie_link_power_mgmt_pkg::SCALE_0_01,
                            pcie_link_power_mgmt_pkg::PB1_BASE_POWER}; // R03 R04 R05 R06
    wire [31:0] pbData   = (pbIndex_q == 8'h00) ? pbEntry0 :
                           (pbIndex_q == pcie_link_power_mgmt_pkg::PB_ENTRY_LAST) ? pbEntry1 :
                           32'h0000_0000; // R02 R25

    // Read mux; unmapped offsets read zero
    wire [31:0] rdMux =
        hitPmCsr  ? {30'h0000_0000, powerState_q} :
        hitLnkCtl ? {30'h0000_0000, aspmCtrl_q} :
        hitHdr    ? pcie_link_power_mgmt_pkg::PB_CAP_HEADER : // R01
        hitIndex  ? {24'h00_0000, pbIndex_q} :
        hitData   ? pbData :
        hitCap    ? pcie_link_power_mgmt_pkg::PB_CAPABILITY_VAL : // R07
        hitUser   ? userCfg_q :
                    32'h0000_0000;

    // Register writes; no reset on D3hot to D0, so settings survive
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            powerState_q <= pcie_link_power_mgmt_pkg::DSTATE_D0;
            aspmCtrl_q   <= 2'h0;
            pbIndex_q    <= 8'h00;
            userCfg_q    <= 32'h0000_0000;
        end
        else
        begin
            if (wrLane0 && hitPmCsr)
                powerState_q <= cfgWdata[1:0]; // R23 R13
            if (wrLane0 && hitLnkCtl)
                aspmCtrl_q <= cfgWdata[1:0]; // R24
            if (wrLane0 && hitIndex)
                pbIndex_q <= cfgWdata[7:0]; // R02
            if (wrLane0 && hitUser)
                userCfg_q[7:0] <= cfgWdata[7:0] & pcie_link_power_mgmt_pkg::UCFG_WRITE_MASK[7:0];
            if (wrLane1 && hitUser)
                userCfg_q[15:8] <= cfgWdata[15:8] & pcie_link_power_mgmt_pkg::UCFG_WRITE_MASK[15:8];
        end
    end

    // Answer one cycle after the request
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfgAck_q   <= 1'b0;
            cfgRdata_q <= 32'h0000_0000;
        end
        else
        begin
            cfgAck_q <= cfgReq;
            if (cfgReq && !cfgWrite)
                cfgRdata_q <= rdMux;
        end
    end

    assign cfgAck   = cfgAck_q;
    assign cfgRdata = cfgRdata_q;

    // ========================================================================
    // Power state decode
    // ========================================================================
    wire dLow     = (powerState_q != pcie_link_power_mgmt_pkg::DSTATE_D0);
    wire dD3hot   = (powerState_q == pcie_link_power_mgmt_pkg::DSTATE_D3HOT);
    wire l1Dis    = userCfg_q[pcie_link_power_mgmt_pkg::UCFG_L1_DIS_BIT];
    wire l0sDis   = userCfg_q[pcie_link_power_mgmt_pkg::UCFG_L0S_DIS_BIT];
    wire idleSel  = userCfg_q[pcie_link_power_mgmt_pkg::UCFG_IDLE_SEL_BIT];
    wire pmeResEn = userCfg_q[pcie_link_power_mgmt_pkg::UCFG_PME_RES_BIT];
    wire aspmL0s  = aspmCtrl_q[pcie_link_power_mgmt_pkg::ASPM_L0S_BIT];
    wire aspmL1   = aspmCtrl_q[pcie_link_power_mgmt_pkg::ASPM_L1_BIT];
    wire l1Allow  = !(dD3hot && l1Dis); // R09

    // ========================================================================
    // Traffic idle counter
    // ========================================================================
    logic [9:0] idleCnt_q;
    wire        trafficIdle = !txPending && rxIdle;
    wire [9:0]  idleThr     = idleSel ? pcie_link_power_mgmt_pkg::L0S_IDLE_LONG_CYC :
                                        pcie_link_power_mgmt_pkg::L0S_IDLE_SHORT_CYC; // R08
    wire        idleDone    = (idleCnt_q == idleThr);

    // Saturates at the threshold; any traffic restarts the wait
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            idleCnt_q <= 10'h000;
        else if (!trafficIdle)
            idleCnt_q <= 10'h000; // R08
        else if (idleCnt_q < idleThr)
            idleCnt_q <= idleCnt_q + 10'h001;
        else
            idleCnt_q <= idleThr;
    end

    // ========================================================================
    // Upstream link state machine
    // ========================================================================
    pcie_link_power_mgmt_pkg::link_state_t state_q;
    pcie_link_power_mgmt_pkg::link_state_t state_d;
    logic turnOffPend_q;

    wire goL23   = turnOffPend_q && !txPending; // R18
    wire goPmL1  = dLow && trafficIdle && l1Allow; // R12 R17
    wire goAspL1 = aspmL1 && idleDone && l1Allow; // R16
    wire goL0s   = aspmL0s && !l0sDis && idleDone; // R10 R14
    wire wake    = txPending || partnerExit; // R16 R17

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            pcie_link_power_mgmt_pkg::LINK_L0:
                if (goL23)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L23NEG;
                else if (goPmL1 || goAspL1)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L1NEG;
                else if (goL0s)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L0S;
            pcie_link_power_mgmt_pkg::LINK_L0S:
                if (txPending || turnOffPend_q)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L0; // R15
                else if (goPmL1 || goAspL1)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L1NEG;
            pcie_link_power_mgmt_pkg::LINK_L1NEG:
                if (l1Rejected || txPending)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L0;
                else if (l1Granted)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L1; // R16 R17
            pcie_link_power_mgmt_pkg::LINK_L1:
                if (wake || turnOffPend_q)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L0; // R16 R17
            pcie_link_power_mgmt_pkg::LINK_L23NEG:
                if (l23Granted)
                    state_d = pcie_link_power_mgmt_pkg::LINK_L23; // R18
            pcie_link_power_mgmt_pkg::LINK_L23:
                state_d = pcie_link_power_mgmt_pkg::LINK_L23; // Left only by reset
            default:
                state_d = pcie_link_power_mgmt_pkg::LINK_L0;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_q <= pcie_link_power_mgmt_pkg::LINK_L0;
        else
            state_q <= state_d;
    end

    wire inL0    = (state_q == pcie_link_power_mgmt_pkg::LINK_L0);
    wire inL0s   = (state_q == pcie_link_power_mgmt_pkg::LINK_L0S);
    wire inL1Neg = (state_q == pcie_link_power_mgmt_pkg::LINK_L1NEG);
    wire inL1    = (state_q == pcie_link_power_mgmt_pkg::LINK_L1);
    wire inL23N  = (state_q == pcie_link_power_mgmt_pkg::LINK_L23NEG);
    wire inL23   = (state_q == pcie_link_power_mgmt_pkg::LINK_L23);
    wire ackNow  = inL0 && goL23;

    // Turn-off is sticky until the ack goes out; a new one wins over the clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            turnOffPend_q <= 1'b0;
        else if (turnOffRcvd)
            turnOffPend_q <= 1'b1;
        else if (ackNow)
            turnOffPend_q <= 1'b0; // R18
    end

    // ========================================================================
    // Registered link and USB side outputs
    // ========================================================================
    logic txIdle_q;
    logic rxLow_q;
    logic toAck_q;
    logic pme_q;
    logic usbDisc_q;

    // Receiver may rest whenever the line is idle, L0s enabled or not
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            txIdle_q  <= 1'b0;
            rxLow_q   <= 1'b0;
            toAck_q   <= 1'b0;
            pme_q     <= 1'b0;
            usbDisc_q <= 1'b0;
        end
        else
        begin
            txIdle_q  <= !(state_d == pcie_link_power_mgmt_pkg::LINK_L0) &&
                         !(state_d == pcie_link_power_mgmt_pkg::LINK_L1NEG); // R14
            rxLow_q   <= rxIdle || inL1 || inL23; // R14
            toAck_q   <= ackNow; // R18
            pme_q     <= pmeResEn && dLow && usbResumeDetect; // R11
            usbDisc_q <= !rcMode && inL23 && !usbSuspended; // R19
        end
    end

    assign txElecIdle     = txIdle_q;
    assign rxLowPower     = rxLow_q;
    assign pmeToAckSend   = toAck_q;
    assign pmeSend        = pme_q;
    assign usbDisconnect  = usbDisc_q;
    assign l1Request      = inL1Neg; // R12
    assign l23Request     = inL23N;
    assign linkState      = state_q;
    assign configOnly     = dLow; // R12
    assign fcTimerFreeze  = inL23; // R22
    assign clockStopAllow = inL23; // R22

    // ========================================================================
    // Downstream port (root-complex mode)
    // ========================================================================
    logic dsL1_q;
    logic dsL23_q;
    logic turnOff_q;

    // Downstream never starts L1 itself; it follows the endpoint
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dsL1_q    <= 1'b0;
            dsL23_q   <= 1'b0;
            turnOff_q <= 1'b0;
        end
        else
        begin
            turnOff_q <= rcMode && turnOffCmd; // R20
            if (rcMode && dsTurnOffAcked)
                dsL23_q <= 1'b1; // R20
            if (rcMode && aspmL1 && epL1Request && dsL1Granted)
                dsL1_q <= 1'b1; // R21
            else if (dsExit || !rcMode)
                dsL1_q <= 1'b0;
        end
    end

    assign turnOffMsgSend = turnOff_q;
    assign dsL1           = dsL1_q;
    assign dsL23Ready     = dsL23_q;

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_hdr_value: assert property ( // R01
        cfgReq && !cfgWrite && hitHdr |=> cfgAck && cfgRdata == 32'h1481_0004)
        else $error("capability header read wrong");
    chk_cap_bit: assert property ( // R07
        cfgReq && !cfgWrite && hitCap |=> cfgRdata[0])
        else $error("system allocated bit not set");
    chk_pb_zero: assert property ( // R25
        cfgReq && !cfgWrite && hitData && pbIndex_q > 8'h01 |=> cfgRdata == 32'h0)
        else $error("unsupported index data not zero");
    chk_l0s_idle: assert property ( // R08
        $rose(inL0s) |-> $past(idleCnt_q) == (idleSel ? pcie_link_power_mgmt_pkg::L0S_IDLE_LONG_CYC
                                                      : pcie_link_power_mgmt_pkg::L0S_IDLE_SHORT_CYC))
        else $error("L0s entered before idle time");
    chk_l0s_disable: assert property ( // R10
        inL0 && l0sDis |=> !inL0s)
        else $error("L0s entered while disabled");
    chk_l0s_exit: assert property ( // R15
        inL0s && txPending |=> inL0 ##1 !txElecIdle)
        else $error("transmit L0s not left on pending packet");
    chk_d3_l1_block: assert property ( // R09
        inL0 && dD3hot && l1Dis |=> !l1Request)
        else $error("L1 requested in D3hot while disabled");
    chk_toack_seq: assert property ( // R18
        inL0 && turnOffPend_q && !txPending |=> pmeToAckSend && l23Request)
        else $error("turn-off ack sequence wrong");
    chk_usb_disc: assert property ( // R19
        inL23 && !rcMode && !usbSuspended |=> usbDisconnect)
        else $error("USB not disconnected in L2/L3 Ready");
    chk_pme_fwd: assert property ( // R11
        pmeResEn && dLow && usbResumeDetect |=> pmeSend)
        else $error("PME not forwarded on USB resume");
    chk_ds_l1: assert property ( // R21
        $rose(dsL1) |-> $past(epL1Request) && $past(rcMode))
        else $error("downstream L1 without endpoint request");

    cov_l0s_cycle: cover property (inL0 ##1 inL0s [*3] ##1 inL0);
    cov_pm_l1: cover property (dLow && inL1Neg ##1 inL1);
    cov_l23: cover property (pmeToAckSend ##[1:20] inL23);

endmodule // pcie_link_power_mgmt

/* test/link_partner.sv */
`timescale 1ns/100ps
// ============================================================================
// Upstream link partner: grants L1 and L2/L3 Ready negotiations
module link_partner
(
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic slow,
    input  wire logic l1Request,
    input  wire logic l23Request,
    output logic      l1Granted,
    output logic      l23Granted
);
    logic [3:0] waitQ;
    // Count request cycles; restart after each grant so a grant is one pulse
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            waitQ <= 4'h0;
        else if ((l1Request || l23Request) && !l1Granted && !l23Granted)
            waitQ <= waitQ + 4'h1;
        else
            waitQ <= 4'h0;
    end
    // Slow mode answers late; no grant is ever given unasked
    assign l1Granted  = l1Request && (waitQ == (slow ? 4'h6 : 4'h1));
    assign l23Granted = l23Request && (waitQ == (slow ? 4'h6 : 4'h1));
endmodule // link_partner

/* test/testbench.sv */
`timescale 1ns/100ps
module testbench;
    logic        mclk, rst_n, cfgReq, cfgWrite, cfgAck, txPending, rxIdle, slow;
    logic [11:0] cfgAddr;
    logic [31:0] cfgWdata, cfgRdata, pbModel [int];
    logic [5:0]  linkState;
    logic        l1Request, l23Request, l1Granted, l23Granted, turnOffRcvd, pmeToAckSend;
    logic        txElecIdle, configOnly, usbSuspended, usbResumeDetect, pmeSend;
    logic        usbDisconnect, fcTimerFreeze, clockStopAllow, turnOffCmd, epL1Request, dsExit;
    logic        rcMode, turnOffMsgSend, rxLowPower, dsL1;
    int          mismatches, checks_done, cyc, idx;
    pcie_link_power_mgmt pcie_link_power_mgmt_inst (.mclk, .rst_n, .cfgReq, .cfgWrite,
        .cfgAddr, .cfgByteEn(4'hf), .cfgWdata, .cfgAck, .cfgRdata, .txPending, .rxIdle,
        .partnerExit(1'b0), .l1Granted, .l1Rejected(1'b0), .turnOffRcvd, .l23Granted,
        .txElecIdle, .rxLowPower, .l1Request, .pmeToAckSend, .l23Request, .linkState,
        .configOnly, .rcMode, .usbSuspended, .usbResumeDetect, .pmeSend, .usbDisconnect,
        .fcTimerFreeze, .clockStopAllow, .turnOffCmd, .dsTurnOffAcked(1'b0), .epL1Request,
        .dsL1Granted(1'b0), .dsExit, .turnOffMsgSend, .dsL1, .dsL23Ready());
    link_partner link_partner_inst (.mclk, .rst_n, .slow, .l1Request, .l23Request,
        .l1Granted, .l23Granted);
    // ========================================================================
    // Clock, hang guard, comparison and closing
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            mismatches++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // One config access; answer lands on the taking edge and is checked 1 ns later
    task automatic cfg(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        cfgReq <= 1'b1;
        cfgWrite <= wr;
        cfgAddr <= a;
        cfgWdata <= d;
        @(posedge mclk);
        cfgReq <= 1'b0;
        #1;
        check(cfgAck, 1'b1);
    endtask
    // Busy during setup so the idle count starts fresh
    task automatic idleRun(input logic [31:0] u, input int lo, input int hi, input logic [5:0] st);
        txPending <= 1'b1;
        cfg(1'b1, 12'h1e0, u);
        @(posedge mclk);
        txPending <= 1'b0;
        repeat (lo) @(posedge mclk);
        #1;
        check(linkState, 6'h01);
        repeat (hi - lo) @(posedge mclk);
        #1;
        check(linkState, st);
    endtask
    // ========================================================================
    // Main sequence
    initial
    begin
        {rst_n, cfgReq, cfgWrite, cfgAddr, cfgWdata, txPending, slow, turnOffRcvd} = '0;
        {usbSuspended, usbResumeDetect, turnOffCmd, epL1Request, dsExit, rcMode} = '0;
        rxIdle = 1'b1;
        pbModel[0] = 32'h00078110;
        pbModel[1] = 32'h00046205;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        idx = $urandom(39068);
        cfg(1'b0, 12'h138, 0);
        check(cfgRdata, 32'h14810004);
        cfg(1'b0, 12'h144, 0);
        check(cfgRdata, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            idx = (i < 2) ? i : $urandom % 256;
            cfg(1'b1, 12'h13c, idx);
            cfg(1'b0, 12'h140, 0);
            check(cfgRdata, pbModel.exists(idx) ? pbModel[idx] : 0);
        end
        $display("test registers done");
        cfg(1'b1, 12'h078, 32'h1);
        idleRun(32'h400, 100, 200, 6'h01);
        idleRun(32'h1, 480, 520, 6'h02);
        check(txElecIdle, 1'b1);
        txPending <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        check(linkState, 6'h01);
        idleRun(32'h0, 115, 135, 6'h02);
        $display("test l0s done");
        txPending <= 1'b1;
        slow <= 1'b1;
        cfg(1'b1, 12'h078, 32'h0);
        cfg(1'b1, 12'h1e0, 32'h1000);
        cfg(1'b1, 12'h044, 32'h3);
        txPending <= 1'b0;
        repeat (14) @(posedge mclk);
        #1;
        check({configOnly, linkState}, 7'h48);
        @(posedge mclk);
        usbResumeDetect <= 1'b1;
        @(posedge mclk);
        usbResumeDetect <= 1'b0;
        #1;
        check(pmeSend, 1'b1);
        txPending <= 1'b1;
        cfg(1'b1, 12'h044, 32'h0);
        check(linkState, 6'h01);
        cfg(1'b1, 12'h1e0, 32'h1080);
        cfg(1'b1, 12'h044, 32'h3);
        txPending <= 1'b0;
        repeat (14) @(posedge mclk);
        #1;
        check(linkState, 6'h01);
        cfg(1'b1, 12'h044, 32'h0);
        cfg(1'b0, 12'h1e0, 0);
        check(cfgRdata, 32'h1080);
        $display("test l1 done");
        txPending <= 1'b0;
        slow <= 1'b0;
        turnOffRcvd <= 1'b1;
        @(posedge mclk);
        turnOffRcvd <= 1'b0;
        @(posedge mclk);
        #1;
        check(pmeToAckSend, 1'b1);
        repeat (6) @(posedge mclk);
        #1;
        check({fcTimerFreeze, clockStopAllow, usbDisconnect, linkState}, 9'h1e0);
        rcMode <= 1'b1;
        rxIdle <= 1'b0;
        turnOffCmd <= 1'b1;
        epL1Request <= 1'b1;
        @(posedge mclk);
        turnOffCmd <= 1'b0;
        #1;
        check({turnOffMsgSend, usbDisconnect, dsL1, rxLowPower}, 4'h9);
        $display("test turn-off done");
        summarize();
    end
endmodule // testbench
